// File: dpps_pkg.sv
// Package for the two-channel drive ownership logic: timing figures,
// pin vector layout and reset values.
// Assumes a single 40 MHz system clock; all channel pins are asynchronous.
package dpps_pkg;
  localparam int CLK_HZ       = 40_000_000;
  localparam int HOLD_MS      = 500;
  localparam int HOLD_CYCLES  = HOLD_MS * (CLK_HZ / 1000);
  localparam int TRIED_US     = 30;
  localparam int TRIED_CYCLES = TRIED_US * (CLK_HZ / 1_000_000);

  localparam int BUS_W     = 10;
  localparam int FORCE_BIT = 9;
  localparam int ADDR_W    = 3;

  // Per channel pin slice: bus, then control select tag, then unit select tag
  localparam int POS_CTL  = BUS_W;
  localparam int POS_UNIT = BUS_W + 1;
  localparam int CH_IN_W  = BUS_W + 2;
  localparam int POS_LOCK = 2 * CH_IN_W;
  localparam int POS_HOLD = POS_LOCK + 2;
  localparam int POS_ADDR = POS_HOLD + 1;
  localparam int SYNC_W   = POS_ADDR + ADDR_W;

  localparam logic RST_FLAG       = 1'h0;
  localparam logic RST_SEEK_END_N = 1'h1;
  localparam logic RST_PHASE      = 1'h0;
endpackage

// File: dpps_timer.sv
// One-shot interval counter: a start pulse arms it for COUNT cycles.
// Assumes start is a one-cycle pulse on SYS_CLK; a new start re-arms it.
`timescale 1ns/1ps
module dpps_timer #(
  parameter int COUNT = 16,
  parameter int W     = (COUNT > 1) ? $clog2(COUNT) : 1
) (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic start,
  output logic      active,
  output logic      done
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic         active;
    logic         done;
  } dpps_tmr_t;

  dpps_tmr_t r;
  dpps_tmr_t n;

  always_comb begin
    n      = r;
    n.done = 1'h0;
    if (start) begin
      n.cnt    = W'(COUNT - 1);
      n.active = 1'h1;
    end else if (r.active) begin
      if (r.cnt == '0) begin
        n.active = 1'h0;
        n.done   = 1'h1;
      end else begin
        n.cnt = r.cnt - W'(1);
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign active = r.active;
  assign done   = r.done;
endmodule

// File: dpps_select.sv
// Two-channel ownership logic for a shared drive: select, reserve,
// forced takeover, release, hold timeout, busy answer and retry notice.
// Assumes two independent controllers drive the channel pins asynchronously.
//
// Behaviour
// - Unit select tag with matching address and bus bit 9 is the forcing select command.
// - A drive held by one channel can still be seized by the other through that command.
// - A forced select disables the owner's channel and selects and reserves for the issuer.
// - Disabling a channel clears its selected and reserved flags and sets the issuer's.
// - A disabled channel stays locked out until the other channel clears its flag.
// - A channel whose lockout switch is set behaves as a disabled channel, but its disabled output stays low.
// - Control select tag with bus bit 9 from the owner clears its reservation and lockout.
// - Timed hold drops the reservation 500 ms after deselect; absolute hold keeps it.
// - A refused attempt sets no selected or reserved flag and answers unit selected together with busy.
// - A refused channel is flagged and, once the drive is free, gets seek end low for 30 us.
`timescale 1ns/1ps
module dpps_select
  import dpps_pkg::*;
#(
  parameter int HOLD_COUNT  = HOLD_CYCLES,
  parameter int TRIED_COUNT = TRIED_CYCLES
) (
  input  wire logic              SYS_CLK,
  input  wire logic              RST,
  input  wire logic              CH1_UNIT_TAG,
  input  wire logic              CH1_CTL_TAG,
  input  wire logic [BUS_W-1:0]  CH1_BUS,
  input  wire logic              CH2_UNIT_TAG,
  input  wire logic              CH2_CTL_TAG,
  input  wire logic [BUS_W-1:0]  CH2_BUS,
  input  wire logic [ADDR_W-1:0] LOGICAL_ADDR,
  input  wire logic              CHANNEL_ONE_LOCKOUT_POSITION,
  input  wire logic              CHANNEL_TWO_LOCKOUT_POSITION,
  input  wire logic              ABSOLUTE_HOLD_SETTING,
  output logic                   CH1_UNIT_SELECTED,
  output logic                   CH1_BUSY,
  output logic                   CH1_SEEK_END_N,
  output logic                   CH1_SELECTED,
  output logic                   CH1_RESERVED,
  output logic                   CH1_DISABLED,
  output logic                   CH2_UNIT_SELECTED,
  output logic                   CH2_BUSY,
  output logic                   CH2_SEEK_END_N,
  output logic                   CH2_SELECTED,
  output logic                   CH2_RESERVED,
  output logic                   CH2_DISABLED
);
  typedef struct packed {
    logic [SYNC_W-1:0] s1;
    logic [SYNC_W-1:0] s2;
    logic              phase;
    logic [1:0]        sel;
    logic [1:0]        res;
    logic [1:0]        dis;
    logic [1:0]        tried;
    logic [1:0]        busy;
    logic [1:0]        unit_sel;
    logic [1:0]        seek_end_n;
    logic [1:0]        hold_start;
    logic [1:0]        pulse_start;
  } dpps_state_t;

  dpps_state_t r;
  dpps_state_t next_r;

  logic [SYNC_W-1:0] raw;
  logic [BUS_W-1:0]  bus_w [2];
  logic [1:0]        tag;
  logic [1:0]        ctl;
  logic [1:0]        maint;
  logic [1:0]        dis_eff;
  logic [1:0]        held_o;
  logic [1:0]        match;
  logic [1:0]        attempt;
  logic [1:0]        my_slot;
  logic [1:0]        force_ev;
  logic [1:0]        select_ev;
  logic [1:0]        refuse;
  logic [1:0]        rel_ev;
  logic [1:0]        hold_done;
  logic [1:0]        pulse_active;
  logic              abs_hold;
  logic [ADDR_W-1:0] addr;

  // Address compare shared by both channels
  function automatic logic addr_hit(input logic [BUS_W-1:0] b, input logic [ADDR_W-1:0] a);
    addr_hit = (b[ADDR_W-1:0] == a);
  endfunction

  // Every pin crosses two flops before any decode reads it
  assign raw      = {LOGICAL_ADDR, ABSOLUTE_HOLD_SETTING,
                     CHANNEL_TWO_LOCKOUT_POSITION, CHANNEL_ONE_LOCKOUT_POSITION,
                     CH2_UNIT_TAG, CH2_CTL_TAG, CH2_BUS,
                     CH1_UNIT_TAG, CH1_CTL_TAG, CH1_BUS};
  assign abs_hold = r.s2[POS_HOLD];
  assign addr     = r.s2[POS_ADDR +: ADDR_W];

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_ch
      assign bus_w[g]     = r.s2[g*CH_IN_W +: BUS_W];
      assign tag[g]       = r.s2[g*CH_IN_W + POS_UNIT];
      assign ctl[g]       = r.s2[g*CH_IN_W + POS_CTL];
      assign maint[g]     = r.s2[POS_LOCK + g];
      assign dis_eff[g]   = r.dis[g] | maint[g];
      assign held_o[g]    = r.sel[1-g] | r.res[1-g];
      assign match[g]     = tag[g] & addr_hit(bus_w[g], addr);
      assign attempt[g]   = match[g] & ~dis_eff[g];
      assign my_slot[g]   = (r.phase == 1'(g));
      assign force_ev[g]  = attempt[g] & bus_w[g][FORCE_BIT] & held_o[g] & my_slot[g];
      assign select_ev[g] = attempt[g] & ~held_o[g] & ~r.sel[g] & my_slot[g];
      assign refuse[g]    = attempt[g] & held_o[g] & ~bus_w[g][FORCE_BIT];
      // Only the reserving or forcing side may release
      assign rel_ev[g]    = ctl[g] & bus_w[g][FORCE_BIT] & ~dis_eff[g]
                          & (r.res[g] | r.dis[1-g]);

      dpps_timer #(.COUNT(HOLD_COUNT)) u_hold (
        .sys_clk (SYS_CLK),
        .rst     (RST),
        .start   (r.hold_start[g]),
        .active  (),
        .done    (hold_done[g])
      );

      dpps_timer #(.COUNT(TRIED_COUNT)) u_pulse (
        .sys_clk (SYS_CLK),
        .rst     (RST),
        .start   (r.pulse_start[g]),
        .active  (pulse_active[g]),
        .done    ()
      );
    end
  endgenerate

  always_comb begin
    next_r             = r;
    next_r.s1          = raw;
    next_r.s2          = r.s1;
    next_r.phase       = ~r.phase;
    next_r.hold_start  = '0;
    next_r.pulse_start = '0;
    for (int i = 0; i < 2; i++) begin
      // Deselect arms the hold timer; reselect before it ends keeps the hold
      if (r.sel[i] && !match[i]) begin
        next_r.sel[i]        = 1'h0;
        next_r.hold_start[i] = 1'h1;
      end
      if (hold_done[i] && !abs_hold && !r.sel[i]) begin
        next_r.res[i] = 1'h0;
      end
    end
    for (int i = 0; i < 2; i++) begin
      if (force_ev[i]) begin
        next_r.dis[1-i] = 1'h1;
        next_r.sel[1-i] = 1'h0;
        next_r.res[1-i] = 1'h0;
        next_r.sel[i]   = 1'h1;
        next_r.res[i]   = 1'h1;
      end else if (select_ev[i]) begin
        next_r.sel[i] = 1'h1;
        next_r.res[i] = 1'h1;
      end
    end
    for (int i = 0; i < 2; i++) begin
      // Release comes last so it wins over a takeover in the same cycle
      if (rel_ev[i]) begin
        next_r.res[i]   = 1'h0;
        next_r.dis[1-i] = 1'h0;
      end
      if (maint[i]) begin
        next_r.sel[i] = 1'h0;
        next_r.res[i] = 1'h0;
      end
      // Set and clear exclude each other, since refusal needs the drive held
      if (refuse[i] && my_slot[i]) begin
        next_r.tried[i] = 1'h1;
      end else if (r.tried[i] && !held_o[i]) begin
        next_r.tried[i]       = 1'h0;
        next_r.pulse_start[i] = 1'h1;
      end
      next_r.busy[i]       = refuse[i];
      next_r.unit_sel[i]   = next_r.sel[i] | refuse[i];
      next_r.seek_end_n[i] = ~pulse_active[i];
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      r            <= '0;
      r.phase      <= RST_PHASE;
      r.sel        <= {2{RST_FLAG}};
      r.res        <= {2{RST_FLAG}};
      r.dis        <= {2{RST_FLAG}};
      r.tried      <= {2{RST_FLAG}};
      r.seek_end_n <= {2{RST_SEEK_END_N}};
    end else begin
      r <= next_r;
    end
  end

  assign CH1_UNIT_SELECTED = r.unit_sel[0];
  assign CH1_BUSY          = r.busy[0];
  assign CH1_SEEK_END_N    = r.seek_end_n[0];
  assign CH1_SELECTED      = r.sel[0];
  assign CH1_RESERVED      = r.res[0];
  assign CH1_DISABLED      = r.dis[0];
  assign CH2_UNIT_SELECTED = r.unit_sel[1];
  assign CH2_BUSY          = r.busy[1];
  assign CH2_SEEK_END_N    = r.seek_end_n[1];
  assign CH2_SELECTED      = r.sel[1];
  assign CH2_RESERVED      = r.res[1];
  assign CH2_DISABLED      = r.dis[1];

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);

  property p_never_both;
    !(r.sel == 2'h3) && !(select_ev == 2'h3);
  endproperty
  a_never_both: assert property (p_never_both) else $error("both channels selected");

  generate
    for (g = 0; g < 2; g++) begin : g_chk
      property p_force_takes;
        force_ev[g] |=> r.sel[g];
      endproperty
      a_force_takes: assert property (p_force_takes)
        else $error("forced select not taken");

      property p_force_locks;
        force_ev[g] && !rel_ev[g] |=> r.res[g] && r.dis[1-g] && !r.sel[1-g] && !r.res[1-g];
      endproperty
      a_force_locks: assert property (p_force_locks)
        else $error("takeover state wrong");

      property p_dis_clears;
        $rose(r.dis[g]) |-> !r.sel[g] && !r.res[g] && r.sel[1-g] && r.res[1-g];
      endproperty
      a_dis_clears: assert property (p_dis_clears) else $error("disable left flags");

      property p_dis_holds;
        r.dis[g] && !rel_ev[1-g] |=> r.dis[g] && !r.sel[g];
      endproperty
      a_dis_holds: assert property (p_dis_holds) else $error("lockout dropped");

      property p_maint;
        maint[g] |=> !r.sel[g] && !r.res[g] && !r.busy[g];
      endproperty
      a_maint: assert property (p_maint) else $error("lockout switch ignored");

      property p_release;
        rel_ev[g] |=> !r.res[g] && !r.dis[1-g];
      endproperty
      a_release: assert property (p_release) else $error("release not applied");

      property p_abs_hold;
        abs_hold && r.res[g] && !rel_ev[g] && !force_ev[1-g] && !maint[g] |=> r.res[g];
      endproperty
      a_abs_hold: assert property (p_abs_hold) else $error("absolute hold lost");

      property p_refuse;
        refuse[g] |=> r.busy[g] && r.unit_sel[g] && !r.sel[g] && !r.res[g];
      endproperty
      a_refuse: assert property (p_refuse) else $error("refusal answer wrong");

      property p_tried_pulse;
        $fell(r.tried[g]) |-> ##[1:3] !r.seek_end_n[g];
      endproperty
      a_tried_pulse: assert property (p_tried_pulse)
        else $error("seek end pulse missing");
    end
  endgenerate
endmodule

// File: dpps_host.sv
// Behavioural model of one channel controller facing the shared drive.
// Assumes the bench calls put from one process at a time, never twice per edge.
`timescale 1ns/1ps
module dpps_host
  import dpps_pkg::*;
(
  input  wire logic        clk,
  output logic             unit_tag,
  output logic             ctl_tag,
  output logic [BUS_W-1:0] bus
);
  logic [BUS_W-1:0] last;

  initial begin
    unit_tag = 1'h0;
    ctl_tag  = 1'h0;
    bus      = '0;
    last     = '0;
  end

  // Levels change just after a falling edge and stand until the next call
  task automatic put(input logic u, input logic c, input logic f,
                     input logic [ADDR_W-1:0] a);
    logic [BUS_W-1:0] b;
    b                = '0;
    b[ADDR_W-1:0]    = a;
    b[FORCE_BIT]     = f;
    @(negedge clk);
    unit_tag = u;
    ctl_tag  = c;
    // An idle bus is not held; showing the inverse keeps stale data from matching
    if (u || c) begin
      bus  = b;
      last = b;
    end else begin
      bus = ~last;
    end
  endtask
endmodule

// File: tb_top.sv
// Self-checking bench for the two-channel drive ownership logic.
// Assumes two controller models on the channel pins; counts shortened by parameters.
`timescale 1ns/1ps
module tb_top;
  import dpps_pkg::*;
  localparam int         HOLD  = 40;
  localparam int         TRIED = 10;
  localparam logic [2:0] A     = 3'h5;
  localparam logic       H     = 1'h1;
  localparam logic       L     = 1'h0;

  typedef struct packed {
    logic       u1, c1, f1;
    logic [2:0] a1;
    logic       u2, c2, f2;
    logic [2:0] a2;
    logic       l1, l2, ab;
    logic [11:0] exp;
  } dpps_row_t;

  // Per channel: unit selected, busy, seek end, selected, reserved, disabled
  localparam dpps_row_t ROWS [14] = '{
    '{H,L,L,A, L,L,L,A, L,L,H, 12'hb88}, '{H,L,L,A, H,L,L,A, L,L,H, 12'hbb8},
    '{H,L,L,A, L,L,L,A, L,L,H, 12'hb88}, '{H,L,L,A, H,L,H,A, L,L,H, 12'h26e},
    '{H,L,L,A, L,L,L,A, L,L,H, 12'h24a}, '{L,L,L,A, L,H,H,A, L,L,H, 12'h208},
    '{L,L,L,A, H,L,L,A, L,H,H, 12'h208}, '{H,L,L,A, H,L,L,A, L,H,H, 12'hb88},
    '{H,L,L,A, H,L,L,A, H,H,H, 12'h208}, '{H,L,L,A, L,L,L,A, L,L,H, 12'hb88},
    '{L,L,L,A, L,L,L,A, L,L,H, 12'h288}, '{H,L,L,A, L,L,L,A, L,L,L, 12'hb88},
    '{L,L,L,A, L,L,L,A, L,L,L, 12'h208}, '{H,L,L,3'h4, L,L,L,A, L,L,L, 12'h208}};

  logic             sys_clk;
  logic             rst;
  logic             lock1;
  logic             lock2;
  logic             abs_hold;
  wire              u1, c1, u2, c2;
  wire  [BUS_W-1:0] b1, b2;
  wire  [5:0]       o1, o2;
  wire  [11:0]      seen = {o1, o2};
  int               num_errors;
  int               samples_checked;
  int               cycles;
  int               n;

  dpps_host u_dpps_host_a (.clk(sys_clk), .unit_tag(u1), .ctl_tag(c1), .bus(b1));
  dpps_host u_dpps_host_b (.clk(sys_clk), .unit_tag(u2), .ctl_tag(c2), .bus(b2));

  dpps_select #(.HOLD_COUNT(HOLD), .TRIED_COUNT(TRIED)) u_dpps_select (
    .SYS_CLK(sys_clk), .RST(rst),
    .CH1_UNIT_TAG(u1), .CH1_CTL_TAG(c1), .CH1_BUS(b1),
    .CH2_UNIT_TAG(u2), .CH2_CTL_TAG(c2), .CH2_BUS(b2),
    .LOGICAL_ADDR(A),
    .CHANNEL_ONE_LOCKOUT_POSITION(lock1), .CHANNEL_TWO_LOCKOUT_POSITION(lock2),
    .ABSOLUTE_HOLD_SETTING(abs_hold),
    .CH1_UNIT_SELECTED(o1[5]), .CH1_BUSY(o1[4]), .CH1_SEEK_END_N(o1[3]),
    .CH1_SELECTED(o1[2]), .CH1_RESERVED(o1[1]), .CH1_DISABLED(o1[0]),
    .CH2_UNIT_SELECTED(o2[5]), .CH2_BUSY(o2[4]), .CH2_SEEK_END_N(o2[3]),
    .CH2_SELECTED(o2[2]), .CH2_RESERVED(o2[1]), .CH2_DISABLED(o2[0]));

  initial begin
    sys_clk = 1'h0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic check(input logic [11:0] got, input logic [11:0] want);
    samples_checked++;
    if (got !== want) begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, want);
    end
  endtask

  task automatic conclude;
    $display("mismatches %0d comparisons %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic apply(input dpps_row_t r);
    fork
      u_dpps_host_a.put(r.u1, r.c1, r.f1, r.a1);
      u_dpps_host_b.put(r.u2, r.c2, r.f2, r.a2);
      begin
        @(negedge sys_clk);
        lock1    = r.l1;
        lock2    = r.l2;
        abs_hold = r.ab;
      end
    join
  endtask

  // Generous ceiling: the sequence needs about 1000 cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      conclude();
    end
  end

  initial begin
    rst      = 1'h1;
    lock1    = 1'h0;
    lock2    = 1'h0;
    abs_hold = 1'h1;
    repeat (12) @(negedge sys_clk);
    rst = 1'h0;
    foreach (ROWS[i]) begin
      apply(ROWS[i]);
      repeat (60) @(negedge sys_clk);
      check(12'(o1), 12'(ROWS[i].exp[11:6]));
      check(12'(o2), 12'(ROWS[i].exp[5:0]));
    end
    // Refused channel gets a notice once the owner releases
    u_dpps_host_a.put(1'h1, 1'h0, 1'h0, A);
    repeat (8) @(negedge sys_clk);
    u_dpps_host_b.put(1'h1, 1'h0, 1'h0, A);
    repeat (8) @(negedge sys_clk);
    check({6'h0, o2}, 12'h038);
    u_dpps_host_b.put(1'h0, 1'h0, 1'h0, A);
    repeat (8) @(negedge sys_clk);
    u_dpps_host_a.put(1'h0, 1'h1, 1'h1, A);
    n = 0;
    while (o2[3] !== 1'h0 && n < 30) begin
      @(negedge sys_clk);
      n++;
    end
    n = 0;
    while (o2[3] === 1'h0 && n < 100) begin
      @(negedge sys_clk);
      n++;
    end
    check(12'(n), 12'(TRIED));
    u_dpps_host_a.put(1'h0, 1'h0, 1'h0, A);
    repeat (8) @(negedge sys_clk);
    // Both channels ask at the same edge: exactly one wins, the other sees busy
    fork
      u_dpps_host_a.put(1'h1, 1'h0, 1'h0, A);
      u_dpps_host_b.put(1'h1, 1'h0, 1'h0, A);
    join
    repeat (8) @(negedge sys_clk);
    check({10'h0, o1[2] ^ o2[2], o1[4] ^ o2[4]}, 12'h003);
    // Second reset in mid-run returns every output to its idle level
    rst = 1'h1;
    repeat (2) @(negedge sys_clk);
    check(seen, 12'h208);
    rst = 1'h0;
    // Synchroniser flops restart at zero, so the held requests stay unseen for two edges
    repeat (2) @(negedge sys_clk);
    check(seen, 12'h208);
    repeat (8) @(negedge sys_clk);
    check({10'h0, o1[2] ^ o2[2], o1[4] ^ o2[4]}, 12'h003);
    // Timed hold: the reservation outlives the deselect, then lapses after the hold count
    fork
      u_dpps_host_a.put(1'h0, 1'h0, 1'h0, A);
      u_dpps_host_b.put(1'h0, 1'h0, 1'h0, A);
    join
    repeat (20) @(negedge sys_clk);
    check({11'h0, o1[1] | o2[1]}, 12'h001);
    repeat (40) @(negedge sys_clk);
    check({11'h0, o1[1] | o2[1]}, 12'h000);
    conclude();
  end
endmodule
